/* File: rtl/cdm_defs.svh */
`ifndef CDM_DEFS_SVH
`define CDM_DEFS_SVH
// Register offsets (register index on the host register port)
`define CDM_OFF_MERGE      7'h0f
`define CDM_OFF_DET_CTRL   7'h10
`define CDM_OFF_TH1        7'h11
`define CDM_OFF_TH2        7'h12
`define CDM_OFF_TH3        7'h13
// Field positions
`define CDM_MERGE_WARN_BIT 1
`define CDM_MERGE_SECONDARY_IRQ_OUT_BIT 0
`define CDM_CAL_EN_BIT     6
`define CDM_PD_NEG_LSB     3
`define CDM_PD_POS_LSB     0
`define CDM_CODE_N_LSB     8
`define CDM_CODE_P_LSB     0
// Reset values
`define CDM_MERGE_RST      16'h0000
`define CDM_DET_CTRL_RST   16'h0000
`define CDM_TH_RST         16'h0000
`endif

/* File: rtl/cdm_pkg.sv */
package cdm_pkg;
    typedef logic [15:0] cdm_word_type;
    typedef logic [6:0]  cdm_addr_type;
    typedef logic [7:0]  cdm_code_type;
endpackage : cdm_pkg

/* File: rtl/cdm_current_detect_cfg.sv */
// Summary of operation
// - Merge bit 1 set: in normal mode without calibration, primary irq out also carries the warning state.
// - Merge bit 0 set: in normal mode without calibration, primary irq out also carries secondary irq state.
// - A write to any detection register latches all four into the detector.
// - Detector latches ignore digital reset and hold in every power mode.
// - Control bit 6 enables detectors in normal mode for calibration.
// - With calibration enabled, both irq outputs follow the detector outputs.
// - Control bits 5 to 3 power down negative detectors of channels 3,2,1.
// - Control bits 2 to 0 power down positive detectors of channels 3,2,1.
// - Channel 1 threshold: negative code upper byte, positive lower; resets zero.
// - Channel 2 threshold: negative code upper byte, positive lower; resets zero.
// - Codes pass straight to the detector: zeros lowest, ones highest threshold.
// - Channel 3 threshold: negative code upper byte, positive lower; resets zero.
`timescale 1ns/1ns
`default_nettype none
`include "cdm_defs.svh"
module cdm_current_detect_cfg (
    input  wire logic                  clock_i,
    input  wire logic                  nrst_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    input  wire cdm_pkg::cdm_addr_type reg_addr_i,
    input  wire cdm_pkg::cdm_word_type reg_wdata_i,
    output logic [15:0]                reg_rdata_o,
    output logic                       reg_hit_o,
    input  wire logic                  detect_mode_i,
    input  wire logic                  primary_irq_state_i,
    input  wire logic                  secondary_irq_state_i,
    input  wire logic                  warn_state_i,
    input  wire logic                  pos_detect_out_i,
    input  wire logic                  neg_detect_out_i,
    output logic                       primary_irq_out_o,
    output logic                       secondary_irq_out_o,
    output logic                       detectors_enabled_o,
    output logic [2:0]                 neg_power_down_o,
    output logic [2:0]                 pos_power_down_o,
    output logic [7:0]                 negative_detector_code_o [3],
    output logic [7:0]                 positive_detector_code_o [3]
);
    import cdm_pkg::*;

    // ************************************************************
    // Register file
    // ************************************************************
    cdm_word_type merge_r;
    cdm_word_type det_ctrl_r;
    cdm_word_type th_r [3];
    logic         det_wr;
    logic         map_hit;

    // Any write into the detection group, offsets 0x10 to 0x13
    assign det_wr = reg_wr_i && (reg_addr_i >= `CDM_OFF_DET_CTRL)
                             && (reg_addr_i <= `CDM_OFF_TH3);
    assign map_hit = (reg_addr_i >= `CDM_OFF_MERGE) && (reg_addr_i <= `CDM_OFF_TH3);

    // Merge register, only the low two bits are implemented
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            merge_r <= `CDM_MERGE_RST;
        end else if (reg_wr_i && reg_addr_i == `CDM_OFF_MERGE) begin
            merge_r <= {14'h0000, reg_wdata_i[1:0]};
        end
    end

    // Control keeps all 16 bits so reads echo what software wrote
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            det_ctrl_r <= `CDM_DET_CTRL_RST;
        end else if (reg_wr_i && reg_addr_i == `CDM_OFF_DET_CTRL) begin
            det_ctrl_r <= reg_wdata_i;
        end
    end

    // Threshold registers, one per channel
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_th
            always_ff @(posedge clock_i) begin
                if (!nrst_i) begin
                    th_r[g] <= `CDM_TH_RST;
                end else if (reg_wr_i && reg_addr_i == cdm_addr_type'(`CDM_OFF_TH1 + g)) begin
                    th_r[g] <= reg_wdata_i;
                end
            end
        end
    endgenerate

    // Read mux returns register shadows, never the latches
    always_comb begin
        reg_rdata_o = 16'h0000;
        case (reg_addr_i)
            `CDM_OFF_MERGE:    reg_rdata_o = merge_r;
            `CDM_OFF_DET_CTRL: reg_rdata_o = det_ctrl_r;
            `CDM_OFF_TH1:      reg_rdata_o = th_r[0];
            `CDM_OFF_TH2:      reg_rdata_o = th_r[1];
            `CDM_OFF_TH3:      reg_rdata_o = th_r[2];
            default:           reg_rdata_o = 16'h0000;
        endcase
    end
    assign reg_hit_o = (reg_rd_i || reg_wr_i) && map_hit;

    // ************************************************************
    // Detector configuration latches
    // ************************************************************
    cdm_word_type lat_ctrl_r;
    cdm_word_type lat_th_r [3];

    // No reset term at all: contents survive digital reset and mode changes.
    // Power-up value is undefined until software writes the group.
    // The written word is forwarded so the just-written value is latched too.
    always_ff @(posedge clock_i) begin
        if (det_wr) begin
            lat_ctrl_r  <= (reg_addr_i == `CDM_OFF_DET_CTRL) ? reg_wdata_i : det_ctrl_r;
            lat_th_r[0] <= (reg_addr_i == `CDM_OFF_TH1) ? reg_wdata_i : th_r[0];
            lat_th_r[1] <= (reg_addr_i == `CDM_OFF_TH2) ? reg_wdata_i : th_r[1];
            lat_th_r[2] <= (reg_addr_i == `CDM_OFF_TH3) ? reg_wdata_i : th_r[2];
        end
    end

    // Bookkeeping for the hold check; like the latches it ignores reset,
    // so it stays unknown, and the check idle, until the group is written
    logic lat_seen_r;
    always_ff @(posedge clock_i) begin
        if (det_wr) begin
            lat_seen_r <= 1'b1;
        end
    end

    // ************************************************************
    // Detector outputs
    // ************************************************************
    logic cal_en;
    assign cal_en              = lat_ctrl_r[`CDM_CAL_EN_BIT];
    assign detectors_enabled_o = cal_en || detect_mode_i;
    assign neg_power_down_o    = lat_ctrl_r[`CDM_PD_NEG_LSB +: 3];
    assign pos_power_down_o    = lat_ctrl_r[`CDM_PD_POS_LSB +: 3];
    generate
        for (g = 0; g < 3; g++) begin : g_code
            // Code is passed unaltered, so threshold rises with code
            assign negative_detector_code_o[g] = lat_th_r[g][`CDM_CODE_N_LSB +: 8];
            assign positive_detector_code_o[g] = lat_th_r[g][`CDM_CODE_P_LSB +: 8];
        end
    endgenerate

    // ************************************************************
    // Interrupt routing
    // ************************************************************
    logic merged_irq;
    assign merged_irq = primary_irq_state_i
                      | (merge_r[`CDM_MERGE_WARN_BIT] & warn_state_i)
                      | (merge_r[`CDM_MERGE_SECONDARY_IRQ_OUT_BIT] & secondary_irq_state_i);

    // Calibration borrows both pins exactly as detection mode does
    always_comb begin
        if (detectors_enabled_o) begin
            primary_irq_out_o   = pos_detect_out_i;
            secondary_irq_out_o = neg_detect_out_i;
        end else begin
            primary_irq_out_o   = merged_irq;
            secondary_irq_out_o = secondary_irq_state_i;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_latch_group;
        @(posedge clock_i) disable iff (!nrst_i)
        (reg_wr_i && reg_addr_i == `CDM_OFF_TH2)
            |=> (lat_th_r[1] == $past(reg_wdata_i)) && (lat_th_r[0] == th_r[0]);
    endproperty
    a_latch_group: assert property (p_latch_group) else $error("latch group not copied");

    property p_latch_hold;
        @(posedge clock_i) (lat_seen_r && !det_wr)
            |=> $stable(lat_ctrl_r) && $stable(lat_th_r[0])
                && $stable(lat_th_r[1]) && $stable(lat_th_r[2]);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write");

    property p_warn_merge;
        @(posedge clock_i) disable iff (!nrst_i)
        (!detectors_enabled_o && merge_r[1] && warn_state_i) |-> primary_irq_out_o;
    endproperty
    a_warn_merge: assert property (p_warn_merge) else $error("warn not merged");

    property p_secondary_irq_out_merge;
        @(posedge clock_i) disable iff (!nrst_i)
        (!detectors_enabled_o && !merge_r[0] && !merge_r[1])
            |-> (primary_irq_out_o == primary_irq_state_i);
    endproperty
    a_secondary_irq_out_merge: assert property (p_secondary_irq_out_merge) else $error("unmerged irq altered");

    property p_secondary_irq_out_or;
        @(posedge clock_i) disable iff (!nrst_i)
        (!detectors_enabled_o && merge_r[`CDM_MERGE_SECONDARY_IRQ_OUT_BIT]
            && secondary_irq_state_i) |-> primary_irq_out_o;
    endproperty
    a_secondary_irq_out_or: assert property (p_secondary_irq_out_or) else $error("secondary irq not merged");

    property p_cal_route;
        @(posedge clock_i) disable iff (!nrst_i)
        cal_en |-> (primary_irq_out_o == pos_detect_out_i)
                && (secondary_irq_out_o == neg_detect_out_i);
    endproperty
    a_cal_route: assert property (p_cal_route) else $error("calibration routing wrong");

    property p_pd_neg;
        @(posedge clock_i) disable iff (!nrst_i)
        (reg_wr_i && reg_addr_i == `CDM_OFF_DET_CTRL)
            |=> neg_power_down_o == $past(reg_wdata_i[5:3]);
    endproperty
    a_pd_neg: assert property (p_pd_neg) else $error("negative power-down wrong");

    property p_pd_pos;
        @(posedge clock_i) disable iff (!nrst_i)
        (reg_wr_i && reg_addr_i == `CDM_OFF_DET_CTRL)
            |=> pos_power_down_o == $past(reg_wdata_i[2:0]);
    endproperty
    a_pd_pos: assert property (p_pd_pos) else $error("positive power-down wrong");

    property p_readback;
        @(posedge clock_i) disable iff (!nrst_i)
        (reg_wr_i && reg_addr_i == `CDM_OFF_TH1)
            ##1 (reg_addr_i == `CDM_OFF_TH1 && !reg_wr_i)
            |-> reg_rdata_o == $past(reg_wdata_i);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");
endmodule : cdm_current_detect_cfg
`default_nettype wire

/* File: verification/cdm_current_detect_cfg_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module cdm_current_detect_cfg_bench;
    import cdm_pkg::*;
    // ****************************************
    // Stimulus signals and model state
    // ****************************************
    logic         clock_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    cdm_addr_type reg_addr_i = '0;
    cdm_word_type reg_wdata_i = '0;
    logic         detect_mode_i = 0, pri_i = 0, sec_i = 0, warn_i = 0, pos_i = 0, neg_i = 0;
    logic [15:0]  reg_rdata_o;
    logic         reg_hit_o, pri_o, sec_o, det_en_o;
    logic [2:0]   neg_pd_o, pos_pd_o;
    logic [7:0]   neg_code_o [3];
    logic [7:0]   pos_code_o [3];
    logic [15:0]  mreg [5];
    logic [15:0]  mlat [4];
    logic         lat_ok = 0;
    int           mismatches = 0, checks = 0;
    logic         ep;
    cdm_addr_type ra;
    cdm_current_detect_cfg uut (.clock_i(clock_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .detect_mode_i(detect_mode_i),
        .primary_irq_state_i(pri_i), .secondary_irq_state_i(sec_i), .warn_state_i(warn_i),
        .pos_detect_out_i(pos_i), .neg_detect_out_i(neg_i), .primary_irq_out_o(pri_o),
        .secondary_irq_out_o(sec_o), .detectors_enabled_o(det_en_o),
        .neg_power_down_o(neg_pd_o), .pos_power_down_o(pos_pd_o),
        .negative_detector_code_o(neg_code_o), .positive_detector_code_o(pos_code_o));
    // 4 ns clock
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    task automatic final_report();
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Readback of every register, then the latch-driven outputs
    task automatic check_all();
        // Inputs move only at falling edges, one register per clock cycle
        for (int i = 0; i < 5; i++) begin
            @(negedge clock_i);
            reg_addr_i = 7'h0f + 7'(i);
            reg_rd_i = 1;
            #1 chk(reg_rdata_o, mreg[i]);
            chk({15'h0000, reg_hit_o}, 16'h0001);
        end
        @(negedge clock_i);
        reg_addr_i = 7'h14;
        #1 chk(reg_rdata_o, 16'h0000);
        chk({15'h0000, reg_hit_o}, 16'h0000);
        @(negedge clock_i);
        reg_rd_i = 0;
        #1;
        if (lat_ok) begin
            for (int g = 0; g < 3; g++) begin
                chk({8'h00, neg_code_o[g]}, {8'h00, mlat[g+1][15:8]});
                chk({8'h00, pos_code_o[g]}, {8'h00, mlat[g+1][7:0]});
            end
            chk({13'h0000, neg_pd_o}, {13'h0000, mlat[0][5:3]});
            chk({13'h0000, pos_pd_o}, {13'h0000, mlat[0][2:0]});
            chk({15'h0000, det_en_o}, {15'h0000, mlat[0][6] | detect_mode_i});
        end
    endtask : check_all
    // One-cycle write strobe; lowered at the next falling edge
    task automatic wr(input cdm_addr_type a, input cdm_word_type d);
        @(negedge clock_i);
        reg_wr_i = 1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clock_i);
        reg_wr_i = 0;
        if (a >= 7'h0f && a <= 7'h13) mreg[a-7'h0f] = (a == 7'h0f) ? (d & 16'h0003) : d;
        if (a >= 7'h10 && a <= 7'h13) begin
            for (int k = 0; k < 4; k++) mlat[k] = mreg[k+1];
            lat_ok = 1;
        end
        check_all();
    endtask : wr
    // Hang guard
    initial begin
        #200000;
        mismatches++;
        final_report();
    end
    initial begin
        void'($urandom(32491));
        for (int i = 0; i < 5; i++) mreg[i] = 16'h0000;
        repeat (10) @(negedge clock_i);
        nrst_i = 1;
        check_all();
        // Random traffic, unmapped places included; control keeps three in 15:7
        for (int n = 0; n < 60; n++) begin
            ra = 7'h0e + 7'($urandom_range(6));
            wr(ra, (ra == 7'h10) ? {9'h003, 7'($urandom)} : 16'($urandom));
        end
        wr(7'h0f, 16'hffff);
        // Irq routing over every merge and calibration setting; 32 input combinations, neg_i derived from pos_i and warn_i
        for (int m = 0; m < 8; m++) begin
            wr(7'h0f, 16'(m & 3));
            wr(7'h10, {9'h003, m[2], 6'($urandom)});
            for (int v = 0; v < 32; v++) begin
                @(negedge clock_i);
                {detect_mode_i, pri_i, sec_i, warn_i, pos_i} = 5'(v);
                neg_i = ~pos_i ^ v[1];
                ep = (detect_mode_i | m[2]) ? pos_i : (pri_i | (m[1] & warn_i) | (m[0] & sec_i));
                #1 chk({15'h0000, pri_o}, {15'h0000, ep});
                chk({15'h0000, sec_o}, {15'h0000, (detect_mode_i | m[2]) ? neg_i : sec_i});
                chk({15'h0000, det_en_o}, {15'h0000, m[2] | detect_mode_i});
            end
        end
        // Mid-run reset: registers clear, latches keep their contents
        @(negedge clock_i);
        nrst_i = 0;
        repeat (2) @(negedge clock_i);
        nrst_i = 1;
        for (int i = 0; i < 5; i++) mreg[i] = 16'h0000;
        check_all();
        wr(7'h12, 16'ha55a);
        final_report();
    end
endmodule : cdm_current_detect_cfg_bench
`default_nettype wire
